// ---- rtl/sdram_precharge_refresh.sv ----
`timescale 1ns/1ps
module sdram_precharge_refresh
    import sdram_cmd_pkg::*;
#(
    parameter bit AUTOMOTIVE = 1'b0
) (
    // Clock and reset.
    input  wire logic                       REF_CLK,
    input  wire logic                       RST,
    // Command pins.
    input  wire logic                       CKE,
    input  wire logic                       CS_N,
    input  wire logic                       RAS_N,
    input  wire logic                       CAS_N,
    input  wire logic                       WE_N,
    input  wire logic [sdram_cmd_pkg::BANK_W-1:0] BA,
    input  wire logic [sdram_cmd_pkg::ADDR_W-1:0] ADDR,
    // Burst length code.
    input  wire logic [2:0]                 BURST_LEN,
    // Write data into the buffer.
    input  wire logic                       WDATA_VALID,
    input  wire logic [sdram_cmd_pkg::DATA_W-1:0] WDATA,
    output logic                            WDATA_READY,
    // Buffered data toward the array.
    output logic                            ARRAY_VALID,
    input  wire logic                       ARRAY_READY,
    output logic [sdram_cmd_pkg::DATA_W-1:0] ARRAY_DATA,
    // Array control and status.
    output logic                            ROW_REFRESH,
    output logic [sdram_cmd_pkg::ROW_W-1:0] REFRESH_ROW,
    output logic [sdram_cmd_pkg::NBANK-1:0] BANK_ACTIVE,
    output logic [sdram_cmd_pkg::NBANK-1:0] BANK_PRECHARGING,
    output logic                            BURST_BUSY,
    output logic                            SELF_REFRESH_ON
);
    import sdram_cmd_pkg::*;

    ////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        logic                           cke;
        logic                           cs_n;
        logic                           ras_n;
        logic                           cas_n;
        logic                           we_n;
        logic [BANK_W-1:0]              ba;
        logic [ADDR_W-1:0]              addr;
        logic [2:0]                     blen;
    } pins_t;

    typedef struct packed {
        pins_t                          p1;
        pins_t                          p2;
        bank_state_t [NBANK-1:0]        bank;
        logic [NBANK-1:0][CNT_W-1:0]    tmr;
        logic                           burst_on;
        logic                           burst_page;
        logic                           burst_ap;
        logic [BANK_W-1:0]              burst_bank;
        logic [CNT_W-1:0]               burst_left;
        logic [ROW_W-1:0]               row_ctr;
        logic                           refresh;
        logic [CNT_W-1:0]               rfc_cnt;
        dev_mode_t                      mode;
        logic                           wready;
        logic [5:0]                     fill;
        logic                           avalid;
        logic [DATA_W-1:0]              adata;
        logic [NBANK-1:0]               act_o;
        logic [NBANK-1:0]               pre_o;
    } core_state_t;

    core_state_t s_r;
    core_state_t s_nxt;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic [DATA_W-1:0] fifo_out_data;
    logic        fifo_pop;
    logic        fifo_push;
    logic        osc_tick;

    // Burst length in beats; zero for a full page that runs until cut, and for the unused codes 4 to 6.
    function automatic logic [CNT_W-1:0] beats(input logic [2:0] code);
        case (code)
            BL_1:    beats = 8'h01;
            BL_2:    beats = 8'h02;
            BL_4:    beats = 8'h04;
            BL_8:    beats = 8'h08;
            default: beats = 8'h00;
        endcase
    endfunction

    function automatic logic [3:0] cmd_of(input pins_t p);
        cmd_of = {p.cs_n, p.ras_n, p.cas_n, p.we_n};
    endfunction

    ////////////////////////////////////////////////////////////////////////

    sdram_data_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (REF_CLK),
        .rst       (RST),
        .in_valid  (fifo_push),
        .in_ready  (fifo_in_ready),
        .in_data   (WDATA),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data)
    );

    sdram_self_osc u_osc (
        .clk    (REF_CLK),
        .rst    (RST),
        .enable (s_r.mode == MD_SELF),
        .tick   (osc_tick)
    );

    // The output stage holds one word; it takes another only once the
    // array has accepted the one it holds, so array stalls fill the FIFO.
    assign fifo_pop = fifo_out_valid && (!s_r.avalid || ARRAY_READY);
    // Only words that saw ready high enter the FIFO, so the registered
    // ready and the fill side never disagree about a handshake.
    assign fifo_push = WDATA_VALID && s_r.wready && fifo_in_ready;

    assign WDATA_READY      = s_r.wready;
    assign ARRAY_VALID      = s_r.avalid;
    assign ARRAY_DATA       = s_r.adata;
    assign ROW_REFRESH      = s_r.refresh;
    assign REFRESH_ROW      = s_r.row_ctr;
    assign BANK_ACTIVE      = s_r.act_o;
    assign BANK_PRECHARGING = s_r.pre_o;
    assign BURST_BUSY       = s_r.burst_on;
    assign SELF_REFRESH_ON  = (s_r.mode != MD_NORMAL) ? 1'b1 : 1'b0;

    ////////////////////////////////////////////////////////////////////////

    always_comb begin
        logic [3:0]        cmd;
        logic              do_refresh;
        logic              live;
        logic [BANK_W-1:0] bk;
        cmd        = CMD_NOP;
        do_refresh = 1'b0;
        live       = 1'b0;
        bk         = '0;
        s_nxt      = s_r;
        s_nxt.p1   = '{cke: CKE, cs_n: CS_N, ras_n: RAS_N, cas_n: CAS_N,
                       we_n: WE_N, ba: BA, addr: ADDR, blen: BURST_LEN};
        s_nxt.p2   = s_r.p1;
        cmd        = cmd_of(s_r.p2);
        bk         = s_r.p2.ba;
        s_nxt.refresh = 1'b0;
        if (s_r.rfc_cnt != '0) begin
            s_nxt.rfc_cnt = s_r.rfc_cnt - 8'h01;
        end

        // Precharge timers return banks to idle.
        for (int i = 0; i < NBANK; i++) begin
            if (s_r.bank[i] == BK_PRECH) begin
                if (s_r.tmr[i] <= 8'h01) begin
                    s_nxt.bank[i] = BK_IDLE;
                    s_nxt.tmr[i]  = '0;
                end else begin
                    s_nxt.tmr[i] = s_r.tmr[i] - 8'h01;
                end
            end
        end

        // Burst countdown; auto precharge begins in the cycle after the last beat.
        if (s_r.burst_on && !s_r.burst_page) begin
            if (s_r.burst_left <= 8'h01) begin
                s_nxt.burst_on = 1'b0;
                if (s_r.burst_ap) begin
                    s_nxt.bank[s_r.burst_bank] = BK_PRECH;
                    s_nxt.tmr[s_r.burst_bank]  = 8'(ROW_PRECHARGE_CYC);
                end
            end else begin
                s_nxt.burst_left = s_r.burst_left - 8'h01;
            end
        end

        case (s_r.mode)
            MD_NORMAL: begin
                // Clock enable low masks commands, except the refresh that
                // carries the request for self refresh.
                live = s_r.p2.cke || (cmd == CMD_REFRESH);
            end
            MD_SELF: begin
                // Internal ticks refresh rows with no command input.
                if (osc_tick) begin
                    do_refresh = 1'b1;
                end
                if (s_r.p2.cke) begin
                    s_nxt.mode = MD_EXIT;
                end
            end
            MD_EXIT: begin
                // A refresh still running finishes before commands count.
                if (s_r.rfc_cnt == '0) begin
                    s_nxt.mode = MD_NORMAL;
                end
            end
            default: begin
                s_nxt.mode = MD_NORMAL;
            end
        endcase

        // Everything but CKE is ignored outside normal mode.
        if (live) begin
            case (cmd)
                CMD_ACTIVE: begin
                    if (s_r.bank[bk] == BK_IDLE) begin
                        s_nxt.bank[bk] = BK_ACTIVE;
                    end
                end
                CMD_READ, CMD_WRITE: begin
                    if (s_r.bank[bk] == BK_ACTIVE) begin
                        s_nxt.burst_on   = 1'b1;
                        s_nxt.burst_bank = bk;
                        s_nxt.burst_left = beats(s_r.p2.blen);
                        s_nxt.burst_page = (s_r.p2.blen == BL_PAGE);
                        // Fresh choice on every command.
                        s_nxt.burst_ap = s_r.p2.addr[PRE_SEL_BIT] &&
                                         (s_r.p2.blen != BL_PAGE);
                    end
                end
                CMD_BURST_END: begin
                    // Row stays active; only the burst stops.
                    s_nxt.burst_on = 1'b0;
                    s_nxt.burst_ap = 1'b0;
                end
                CMD_PRECHARGE: begin
                    for (int i = 0; i < NBANK; i++) begin
                        if ((s_r.p2.addr[PRE_SEL_BIT] || bk == i[1:0]) &&
                            s_r.bank[i] == BK_ACTIVE) begin
                            s_nxt.bank[i] = BK_PRECH;
                            s_nxt.tmr[i]  = 8'(ROW_PRECHARGE_CYC);
                        end
                    end
                end
                CMD_REFRESH: begin
                    // One row per command, address pins unused.
                    do_refresh = 1'b1;
                    if (!s_r.p2.cke && !AUTOMOTIVE) begin
                        s_nxt.mode = MD_SELF;
                    end
                end
                default: begin
                end
            endcase
        end

        if (do_refresh) begin
            s_nxt.refresh = 1'b1;
            s_nxt.row_ctr = s_r.row_ctr + 12'h001;
            s_nxt.rfc_cnt = 8'(REFRESH_CYCLE_CYC);
        end

        // Registered output copies.
        for (int i = 0; i < NBANK; i++) begin
            s_nxt.act_o[i] = (s_nxt.bank[i] == BK_ACTIVE);
            s_nxt.pre_o[i] = (s_nxt.bank[i] == BK_PRECH);
        end
        s_nxt.fill   = s_r.fill + 6'(fifo_push) - 6'(fifo_pop);
        s_nxt.wready = (s_nxt.fill != 6'(FIFO_DEPTH));
        if (fifo_pop) begin
            s_nxt.avalid = 1'b1;
            s_nxt.adata  = fifo_out_data;
        end else if (ARRAY_READY) begin
            s_nxt.avalid = 1'b0;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            s_r          <= '0;
            s_r.p1       <= '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1,
                              cas_n: 1'b1, we_n: 1'b1, ba: '0, addr: '0,
                              blen: '0};
            s_r.p2       <= '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1,
                              cas_n: 1'b1, we_n: 1'b1, ba: '0, addr: '0,
                              blen: '0};
            s_r.bank     <= '{default: BK_IDLE};
            s_r.mode     <= MD_NORMAL;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

// ---- rtl/sdram_cmd_pkg.sv ----
package sdram_cmd_pkg;

    // Command encodings on {cs_n, ras_n, cas_n, we_n}.
    localparam logic [3:0] CMD_NOP       = 4'h7;
    localparam logic [3:0] CMD_ACTIVE    = 4'h3;
    localparam logic [3:0] CMD_READ      = 4'h5;
    localparam logic [3:0] CMD_WRITE     = 4'h4;
    localparam logic [3:0] CMD_BURST_END = 4'h6;
    localparam logic [3:0] CMD_PRECHARGE = 4'h2;
    localparam logic [3:0] CMD_REFRESH   = 4'h1;

    localparam int ADDR_W    = 12;
    localparam int BANK_W    = 2;
    localparam int NBANK     = 4;
    localparam int ROW_W     = 12;
    localparam int DATA_W    = 32;
    localparam int FIFO_DEPTH = 32;
    localparam int PRE_SEL_BIT = 10;

    // Burst length codes on the burst length input.
    localparam logic [2:0] BL_1    = 3'h0;
    localparam logic [2:0] BL_2    = 3'h1;
    localparam logic [2:0] BL_4    = 3'h2;
    localparam logic [2:0] BL_8    = 3'h3;
    localparam logic [2:0] BL_PAGE = 3'h7;

    // Timing in ps and the derived cycle counts at 40 MHz.
    localparam int CLK_PERIOD_PS          = 25000;
    localparam int ROW_PRECHARGE_TIME_PS  = 20000;
    localparam int ROW_PRECHARGE_CYC      =
        (ROW_PRECHARGE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int REFRESH_CYCLE_TIME_PS  = 70000;
    localparam int REFRESH_CYCLE_CYC      =
        (REFRESH_CYCLE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Internal oscillator refresh period in self refresh, in ns.
    localparam int SELF_REFRESH_INTERVAL_NS = 15625;
    localparam int SELF_REFRESH_INTERVAL_CYC =
        SELF_REFRESH_INTERVAL_NS * 1000 / CLK_PERIOD_PS;
    localparam int SELF_OSC_DIV_W = 10;
    localparam int CNT_W = 8;

    typedef enum logic [2:0] {
        BK_IDLE   = 3'b001,
        BK_ACTIVE = 3'b010,
        BK_PRECH  = 3'b100
    } bank_state_t;

    typedef enum logic [2:0] {
        MD_NORMAL = 3'b001,
        MD_SELF   = 3'b010,
        MD_EXIT   = 3'b100
    } dev_mode_t;

endpackage

// ---- rtl/sdram_data_fifo.sv ----
`timescale 1ns/1ps
module sdram_data_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             rst,
    // Fill side.
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side.
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
    } fifo_state_t;

    fifo_state_t s_r;
    fifo_state_t s_nxt;
    logic        push;
    logic        pop;

    assign in_ready  = (s_r.cnt != (AW+1)'(DEPTH));
    assign out_valid = (s_r.cnt != '0);
    assign out_data  = s_r.mem[s_r.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        s_nxt = s_r;
        if (push) begin
            s_nxt.mem[s_r.wr] = in_data;
            s_nxt.wr = s_r.wr + 1'b1;
        end
        if (pop) begin
            s_nxt.rd = s_r.rd + 1'b1;
        end
        s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

// ---- rtl/sdram_self_osc.sv ----
`timescale 1ns/1ps
// Stands in for the internal refresh oscillator: a free divider that
// yields one-cycle refresh ticks while enabled.
module sdram_self_osc
    import sdram_cmd_pkg::*;
(
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst,
    // Control and tick.
    input  wire logic enable,
    output logic      tick
);
    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } osc_state_t;

    osc_state_t s_r;
    osc_state_t s_nxt;

    assign tick = s_r.tick;

    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (!enable) begin
            s_nxt.cnt = '0;
        end else if (s_r.cnt == 16'(SELF_REFRESH_INTERVAL_CYC - 1)) begin
            s_nxt.cnt  = '0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

// ---- tb/sdram_precharge_refresh_assertions.sv ----
`timescale 1ns/1ps
module sdram_precharge_refresh_assertions
    import sdram_cmd_pkg::*;
#(
    parameter bit AUTOMOTIVE = 1'b0
) (
    // Clock and reset.
    input wire logic                            REF_CLK,
    input wire logic                            RST,
    // Observed pins.
    input wire logic                            CKE,
    input wire logic                            ROW_REFRESH,
    input wire logic [sdram_cmd_pkg::ROW_W-1:0] REFRESH_ROW,
    input wire logic [sdram_cmd_pkg::NBANK-1:0] BANK_ACTIVE,
    input wire logic [sdram_cmd_pkg::NBANK-1:0] BANK_PRECHARGING,
    input wire logic                            SELF_REFRESH_ON
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    // The oscillator restarts from zero on entry; allow slack for the tick pipeline.
    localparam int TICK_LIMIT = SELF_REFRESH_INTERVAL_CYC + 8;
    logic [11:0] quiet_r;
    logic [11:0] quiet_nxt;

    always_comb begin
        quiet_nxt = quiet_r + 12'h001;
        if (!SELF_REFRESH_ON || ROW_REFRESH) begin
            quiet_nxt = 12'h000;
        end
    end

    always_ff @(posedge REF_CLK) begin
        quiet_r <= RST ? 12'h000 : quiet_nxt;
    end

    sequence exit_request;
        SELF_REFRESH_ON && $rose(CKE);
    endsequence

    ////////////////////////////////////////
    a_refresh_pulse_once:
        assert property (ROW_REFRESH |=> !ROW_REFRESH)
        else $error("refresh pulse longer than one cycle");
    a_row_holds_still:
        assert property (!ROW_REFRESH && !$past(ROW_REFRESH) && !$past(RST)
            |-> $stable(REFRESH_ROW))
        else $error("refresh row moved without a refresh");
    a_row_steps_one:
        assert property (!$past(RST) && $changed(REFRESH_ROW)
            |-> REFRESH_ROW == $past(REFRESH_ROW) + 12'h001)
        else $error("refresh row did not step by one");
    a_bank_state_exclusive:
        assert property ((BANK_ACTIVE & BANK_PRECHARGING) == 4'h0)
        else $error("bank both active and precharging");
    a_precharge_ends:
        assert property (BANK_PRECHARGING[0] |-> ##[1:4] !BANK_PRECHARGING[0])
        else $error("bank zero precharge did not finish");
    a_self_stays_low:
        assert property (SELF_REFRESH_ON && !CKE |=> SELF_REFRESH_ON)
        else $error("self refresh left with clock enable low");
    a_self_banks_frozen:
        assert property (SELF_REFRESH_ON && $past(SELF_REFRESH_ON)
            |-> $stable(BANK_ACTIVE))
        else $error("bank state changed in self refresh");
    a_self_tick_due:
        assert property (int'(quiet_r) <= TICK_LIMIT)
        else $error("self refresh went too long without a refresh");
    a_self_exit_bound:
        assert property (exit_request |-> ##[1:16] !SELF_REFRESH_ON)
        else $error("self refresh exit took too long");
    a_grade_no_self:
        assert property (AUTOMOTIVE |-> !SELF_REFRESH_ON)
        else $error("self refresh on a grade without it");
endmodule

bind sdram_precharge_refresh sdram_precharge_refresh_assertions #(
    .AUTOMOTIVE(AUTOMOTIVE)
) assert_inst (
    .REF_CLK(REF_CLK), .RST(RST), .CKE(CKE), .ROW_REFRESH(ROW_REFRESH),
    .REFRESH_ROW(REFRESH_ROW), .BANK_ACTIVE(BANK_ACTIVE),
    .BANK_PRECHARGING(BANK_PRECHARGING), .SELF_REFRESH_ON(SELF_REFRESH_ON)
);

// ---- tb/sdram_ctrl_model.sv ----
`timescale 1ns/1ps
module sdram_ctrl_model
    import sdram_cmd_pkg::*;
#(
    parameter int ROW_ACTIVE_CYC = 2,
    parameter int SELF_EXIT_CYC  = 4
) (
    // Clock.
    input  wire logic                        clk,
    // Command pins toward the device.
    output logic                             cke,
    output logic [3:0]                       cmd,
    output logic [sdram_cmd_pkg::BANK_W-1:0] ba,
    output logic [sdram_cmd_pkg::ADDR_W-1:0] addr,
    output logic [2:0]                       burst_len
);
    initial begin
        cke = 1'b1;
        cmd = CMD_NOP;
        ba = 2'h0;
        addr = 12'h000;
        burst_len = BL_1;
    end

    task automatic nops(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Released bank and address lines show the inverse of the last value, so a device that
    // wrongly samples them outside a command cannot read a stale copy.
    task automatic issue(input logic [3:0] c, input logic [1:0] b,
                         input logic [11:0] a, input logic [2:0] l);
        @(posedge clk);
        #1;
        cmd = c;
        ba = b;
        addr = a;
        burst_len = l;
        @(posedge clk);
        #1;
        cmd = CMD_NOP;
        ba = ~b;
        addr = ~a;
    endtask

    task automatic refresh(input logic [11:0] a);
        issue(CMD_REFRESH, 2'h0, a, BL_1);
        nops(REFRESH_CYCLE_CYC);
    endtask

    task automatic enter_self();
        @(posedge clk);
        #1;
        cke = 1'b0;
        issue(CMD_REFRESH, 2'h0, 12'h000, BL_1);
    endtask

    task automatic exit_self();
        nops(ROW_ACTIVE_CYC);
        @(posedge clk);
        #1;
        cke = 1'b1;
        nops(SELF_EXIT_CYC);
    endtask
endmodule

// ---- tb/sdram_precharge_refresh_test.sv ----
`timescale 1ns/1ps
`define CHECK(what, exp, got) \
    begin \
        check_count++; \
        if ((got) !== (exp)) begin \
            bad_count++; \
            $display("Error %s expected %h seen %h", what, exp, got); \
        end \
    end
module sdram_precharge_refresh_test;
    import sdram_cmd_pkg::*;
    logic              ref_clk;
    logic              rst;
    logic              wdata_valid;
    logic [DATA_W-1:0] wdata;
    logic              array_ready;
    wire               cke;
    wire  [3:0]        cmd_pins;
    wire  [BANK_W-1:0] ba;
    wire  [ADDR_W-1:0] addr;
    wire  [2:0]        burst_len;
    wire               wdata_ready;
    wire               array_valid;
    wire  [DATA_W-1:0] array_data;
    wire               row_refresh;
    wire  [ROW_W-1:0]  refresh_row;
    wire  [NBANK-1:0]  bank_active;
    wire  [NBANK-1:0]  bank_prech;
    wire               burst_busy;
    wire               self_on;
    wire               at_self_on;
    int                bad_count;
    int                check_count;

    sdram_ctrl_model sdram_ctrl_model_inst (
        .clk(ref_clk), .cke(cke), .cmd(cmd_pins), .ba(ba), .addr(addr),
        .burst_len(burst_len));

    sdram_precharge_refresh sdram_precharge_refresh_inst (
        .REF_CLK(ref_clk), .RST(rst), .CKE(cke), .CS_N(cmd_pins[3]),
        .RAS_N(cmd_pins[2]), .CAS_N(cmd_pins[1]), .WE_N(cmd_pins[0]),
        .BA(ba), .ADDR(addr), .BURST_LEN(burst_len),
        .WDATA_VALID(wdata_valid), .WDATA(wdata), .WDATA_READY(wdata_ready),
        .ARRAY_VALID(array_valid), .ARRAY_READY(array_ready),
        .ARRAY_DATA(array_data), .ROW_REFRESH(row_refresh),
        .REFRESH_ROW(refresh_row), .BANK_ACTIVE(bank_active),
        .BANK_PRECHARGING(bank_prech), .BURST_BUSY(burst_busy),
        .SELF_REFRESH_ON(self_on));

    // Second grade shares the pins; only its self refresh flag is judged.
    sdram_precharge_refresh #(.AUTOMOTIVE(1'b1)) sdram_precharge_refresh_at_inst (
        .REF_CLK(ref_clk), .RST(rst), .CKE(cke), .CS_N(cmd_pins[3]),
        .RAS_N(cmd_pins[2]), .CAS_N(cmd_pins[1]), .WE_N(cmd_pins[0]),
        .BA(ba), .ADDR(addr), .BURST_LEN(burst_len),
        .WDATA_VALID(wdata_valid), .WDATA(wdata), .WDATA_READY(),
        .ARRAY_VALID(), .ARRAY_READY(array_ready), .ARRAY_DATA(),
        .ROW_REFRESH(), .REFRESH_ROW(), .BANK_ACTIVE(), .BANK_PRECHARGING(),
        .BURST_BUSY(), .SELF_REFRESH_ON(at_self_on));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic cmd(input logic [3:0] c, input logic [1:0] b,
                       input logic [11:0] a, input logic [2:0] l);
        sdram_ctrl_model_inst.issue(c, b, a, l);
    endtask

    task automatic pulses(input int cyc, inout int p);
        repeat (cyc) begin
            @(posedge ref_clk);
            if (row_refresh === 1'b1) p++;
        end
        #1;
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////
    task automatic t_reset();
        `CHECK("banks idle", 4'h0, bank_active)
        `CHECK("no self", 1'b0, self_on)
        `CHECK("row count", 12'h000, refresh_row)
        `CHECK("fill ready", 1'b1, wdata_ready)
    endtask

    task automatic t_fifo();
        int n;
        int m;
        n = 0;
        m = 0;
        wdata_valid = 1'b1;
        wdata = 32'ha5000000;
        repeat (40) begin
            @(posedge ref_clk);
            if (wdata_ready === 1'b1) n++;
            #1 wdata = 32'ha5000000 + n;
        end
        `CHECK("words held", FIFO_DEPTH + 1, n)
        `CHECK("stalled valid", 1'b1, array_valid)
        wdata_valid = 1'b0;
        array_ready = 1'b1;
        repeat (40) begin
            @(posedge ref_clk);
            if (array_valid === 1'b1) begin
                `CHECK("drain order", 32'ha5000000 + m, array_data)
                m++;
            end
        end
        #1;
        `CHECK("words drained", FIFO_DEPTH + 1, m)
        `CHECK("drained empty", 1'b0, array_valid)
    endtask

    task automatic ap_cycles(input logic [2:0] l, output int n);
        cmd(CMD_ACTIVE, 2'h0, 12'h000, BL_1);
        wait_cyc(4);
        cmd(CMD_WRITE, 2'h0, 12'h400, l);
        n = 0;
        while (bank_prech[0] !== 1'b1 && n < 40) begin
            @(posedge ref_clk);
            n++;
        end
        wait_cyc(ROW_PRECHARGE_CYC + 2);
        `CHECK("bank closed", 1'b0, bank_active[0])
    endtask

    task automatic t_auto_precharge();
        int n1;
        int n8;
        ap_cycles(BL_1, n1);
        ap_cycles(BL_8, n8);
        `CHECK("precharge seen", 1'b1, n8 < 40)
        `CHECK("precharge point", 7, n8 - n1)
    endtask

    task automatic t_open_rows();
        cmd(CMD_ACTIVE, 2'h0, 12'h000, BL_1);
        cmd(CMD_ACTIVE, 2'h1, 12'h000, BL_1);
        wait_cyc(4);
        `CHECK("banks open", 4'h3, bank_active)
        cmd(CMD_READ, 2'h1, 12'h000, BL_4);
        cmd(CMD_READ, 2'h0, 12'h000, BL_2);
        wait_cyc(12);
        `CHECK("rows kept", 4'h3, bank_active)
        `CHECK("no precharge", 4'h0, bank_prech)
    endtask

    task automatic t_terminate();
        cmd(CMD_ACTIVE, 2'h2, 12'h000, BL_1);
        wait_cyc(4);
        cmd(CMD_READ, 2'h2, 12'h400, BL_PAGE);
        wait_cyc(12);
        `CHECK("page busy", 1'b1, burst_busy)
        `CHECK("page open", 4'h7, bank_active)
        cmd(CMD_BURST_END, 2'h0, 12'h000, BL_1);
        wait_cyc(4);
        `CHECK("burst cut", 1'b0, burst_busy)
        `CHECK("row left open", 4'h7, bank_active)
        cmd(CMD_PRECHARGE, 2'h2, 12'h000, BL_1);
        wait_cyc(4);
        `CHECK("one bank shut", 4'h3, bank_active)
        cmd(CMD_PRECHARGE, 2'h0, 12'h400, BL_1);
        wait_cyc(4);
        `CHECK("all shut", 4'h0, bank_active)
    endtask

    task automatic t_refresh();
        logic [ROW_W-1:0] r0;
        int               p;
        r0 = refresh_row;
        p = 0;
        repeat (2) begin
            cmd(CMD_REFRESH, 2'h0, 12'h5a5, BL_1);
            pulses(8, p);
        end
        `CHECK("one per command", 2, p)
        `CHECK("counter row", r0 + 12'h002, refresh_row)
    endtask

    task automatic t_self();
        logic [ROW_W-1:0] r0;
        int               p;
        int               i;
        r0 = refresh_row;
        p = 0;
        sdram_ctrl_model_inst.enter_self();
        pulses(5, p);
        `CHECK("self entered", 1'b1, self_on)
        `CHECK("grade without self", 1'b0, at_self_on)
        cmd(CMD_ACTIVE, 2'h3, 12'h000, BL_1);
        pulses(700, p);
        `CHECK("pins ignored", 4'h0, bank_active)
        `CHECK("self ticks", 1'b1, p >= 2)
        `CHECK("shared counter", r0 + 12'(p), refresh_row)
        sdram_ctrl_model_inst.exit_self();
        for (i = 0; i < 20 && self_on !== 1'b0; i++) @(posedge ref_clk);
        #1;
        `CHECK("self left", 1'b0, self_on)
        r0 = refresh_row;
        p = 0;
        sdram_ctrl_model_inst.refresh(12'h0f0);
        pulses(8, p);
        `CHECK("counter resumes", r0 + 12'h001, refresh_row)
    endtask

    ////////////////////////////////////////
    initial begin
        bad_count = 0;
        check_count = 0;
        rst = 1'b1;
        wdata_valid = 1'b0;
        wdata = 32'h00000000;
        array_ready = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1 rst = 1'b0;
        wait_cyc(2);
        t_reset();
        t_fifo();
        t_auto_precharge();
        t_open_rows();
        t_terminate();
        t_refresh();
        t_self();
        complete_run();
    end

    // The whole sequence needs about 950 cycles.
    initial begin
        repeat (10000) @(posedge ref_clk);
        bad_count++;
        complete_run();
    end
endmodule
